// >>> pkg/pfgp_pkg.sv
// Purpose: shared constants for the power-failure status and policy block
// Assumes: 8-bit configuration offsets, 16-bit configuration data path
// Notes:   sleep-state codes match the encoding of the sleep_state input

// ----------------------------------------------------------------------
// constants
// ----------------------------------------------------------------------
package pfgp_pkg;

    // configuration offsets of the two registers
    localparam logic [7:0] PFGP_OFS_CFG_TWO = 8'ha2;
    localparam logic [7:0] PFGP_OFS_CFG_THREE = 8'ha4;

    // field positions
    localparam int PFGP_BIT_PG_FAIL = 0;      // power_config_two
    localparam int PFGP_BIT_POLICY = 0;       // power_config_three
    localparam int PFGP_BIT_TRICKLE = 1;      // power_config_three
    localparam int PFGP_BIT_RTC_BATT = 2;     // power_config_three

    // reset values; only PFGP_RST_CFG_TWO is used, power_config_three resets to 16'h0004
    localparam logic [15:0] PFGP_RST_CFG_TWO = 16'h0000;
    localparam logic [7:0] PFGP_RST_CFG_THREE = 8'h00;

    // sleep-state codes carried on the sleep_state input and boot target
    localparam logic [2:0] PFGP_S0 = 3'h0;
    localparam logic [2:0] PFGP_S1 = 3'h1;
    localparam logic [2:0] PFGP_S3 = 3'h3;
    localparam logic [2:0] PFGP_S4 = 3'h4;
    localparam logic [2:0] PFGP_S5 = 3'h5;

    // pin synchroniser depth
    localparam int PFGP_SYNC_DEPTH = 3;

    // power-loss tracking states
    typedef enum logic [1:0] {
        PFGP_RUN,
        PFGP_PG_LOW,
        PFGP_G3
    } pfgp_loss_e;

endpackage : pfgp_pkg

// >>> rtl/pfgp_sync.sv
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to ref_clk
// Notes:   output changes only when the second and third stages agree

`timescale 1ns/10ps

module pfgp_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic pin,
    output logic level_q
);

    // ------------------------------------------------------------------
    // stages
    // ------------------------------------------------------------------
    logic [pfgp_pkg::PFGP_SYNC_DEPTH-1:0] stage_q; // stage 0 is metastable
    logic agree; // last two stages match

    assign agree = (stage_q[1] == stage_q[2]);

    // shift chain; stage 0 feeds only stage 1
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_q <= {pfgp_pkg::PFGP_SYNC_DEPTH{RESET_VAL}};
        end else begin
            stage_q <= {stage_q[1:0], pin};
        end
    end

    // accepted level follows only once the later stages agree
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            level_q <= RESET_VAL;
        end else if (agree) begin
            level_q <= stage_q[2];
        end
    end

endmodule : pfgp_sync

// >>> rtl/pfgp_top.sv
// Purpose: power-failure status flags and after-power-loss boot policy
// Assumes: rst_b is the RTC-well power-on reset; config access is a
//          one-cycle read or write strobe from the configuration decoder
// Notes:   power pins are synchronised; sleep_state is same-clock logic

`timescale 1ns/10ps

module pfgp_top #(
    parameter int WAKE_W = 8 // number of wake event lines
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic power_good_input,
    input wire logic resume_well_reset_n,
    input wire logic rtc_well_reset_n,
    input wire logic [2:0] sleep_state,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [1:0] cfg_be,
    input wire logic [15:0] cfg_wdata,
    input wire logic rst_ctl_wr,
    input wire logic power_button,
    input wire logic [WAKE_W-1:0] wake_event,
    input wire logic [WAKE_W-1:0] wake_kept_en,
    output logic [15:0] cfg_rdata_q,
    output logic boot_req_q,
    output logic [2:0] boot_state_q,
    output logic int_resume_reset_q,
    output logic wake_accept_q
);

    // every check samples on the rising clock and rests during reset
    default clocking a_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (WAKE_W < 1 || WAKE_W > 16) begin : g_bad_wake_w
        $error("pfgp_top: WAKE_W must be 1 to 16");
    end

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic pg_s; // filtered power good
    logic rsm_n_s; // filtered resume-well reset, active low
    logic rtc_n_s; // filtered RTC-well reset, active low
    logic [2:0] pin_raw; // raw power pins, one synchroniser each
    logic [2:0] pin_s; // filtered power pins

    assign pin_raw = {rtc_well_reset_n, resume_well_reset_n,
                      power_good_input};
    assign pg_s = pin_s[0];
    assign rsm_n_s = pin_s[1];
    assign rtc_n_s = pin_s[2];

    // all pins reset low, matching the edge-detector history
    for (genvar i = 0; i < 3; i++) begin : g_sync
        pfgp_sync #(.RESET_VAL(1'b0)) u_sync (
            .ref_clk(ref_clk),
            .rst_b(rst_b),
            .pin(pin_raw[i]),
            .level_q(pin_s[i])
        );
    end

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    logic pg_prev_q; // power good one cycle ago
    logic rsm_prev_q; // resume reset (active low) one cycle ago
    logic pg_fall; // power good dropped
    logic rsm_fall; // resume reset asserted
    logic in_s0_s1; // system running or in light sleep

    assign pg_fall = pg_prev_q & ~pg_s;
    assign rsm_fall = rsm_prev_q & ~rsm_n_s;
    assign in_s0_s1 = (sleep_state == pfgp_pkg::PFGP_S0) |
                      (sleep_state == pfgp_pkg::PFGP_S1);

    // history registers for the edge detectors
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pg_prev_q <= 1'b0;
            rsm_prev_q <= 1'b0;
        end else begin
            pg_prev_q <= pg_s;
            rsm_prev_q <= rsm_n_s;
        end
    end

    // ------------------------------------------------------------------
    // configuration write decode
    // ------------------------------------------------------------------
    logic wr_two; // low byte of power_config_two written
    logic wr_three; // power_config_three written
    logic pg_fail_clr; // write-one to power-good failure flag
    logic rtc_batt_clr; // write-zero to battery flag
    logic trickle_clr; // write-one to trickle flag

    assign wr_two = cfg_wr & cfg_be[0] &
                    (cfg_addr == pfgp_pkg::PFGP_OFS_CFG_TWO);
    assign wr_three = cfg_wr & cfg_be[0] &
                      (cfg_addr == pfgp_pkg::PFGP_OFS_CFG_THREE);
    assign pg_fail_clr = wr_two & cfg_wdata[pfgp_pkg::PFGP_BIT_PG_FAIL];
    assign rtc_batt_clr = wr_three &
                          ~cfg_wdata[pfgp_pkg::PFGP_BIT_RTC_BATT];
    assign trickle_clr = wr_three &
                         cfg_wdata[pfgp_pkg::PFGP_BIT_TRICKLE];

    // ------------------------------------------------------------------
    // power-loss tracking machine
    // ------------------------------------------------------------------
    pfgp_pkg::pfgp_loss_e loss_q; // current loss state
    pfgp_pkg::pfgp_loss_e loss_d; // next loss state
    logic was_s4_q; // system was in S4 when power went
    logic g3_enter; // entering full power failure
    logic boot_go; // power back, decide target this cycle
    logic [2:0] boot_target; // chosen target state
    logic policy_q; // after_power_loss_policy

    // full failure once resume reset asserts from any state but G3
    assign g3_enter = ~rsm_n_s & (loss_q != pfgp_pkg::PFGP_G3);

    // next-state logic
    always_comb begin
        loss_d = loss_q;
        unique case (loss_q)
            pfgp_pkg::PFGP_RUN: begin
                if (!rsm_n_s) begin
                    loss_d = pfgp_pkg::PFGP_G3;
                end else if (pg_fall) begin
                    loss_d = pfgp_pkg::PFGP_PG_LOW;
                end
            end
            pfgp_pkg::PFGP_PG_LOW: begin
                if (!rsm_n_s) begin
                    loss_d = pfgp_pkg::PFGP_G3;
                end else if (pg_s) begin
                    loss_d = pfgp_pkg::PFGP_RUN;
                end
            end
            pfgp_pkg::PFGP_G3: begin
                if (rsm_n_s && pg_s) begin
                    loss_d = pfgp_pkg::PFGP_RUN;
                end
            end
        endcase
    end

    // boot decision on the cycle the machine returns to run
    assign boot_go = (loss_q != pfgp_pkg::PFGP_RUN) &
                     (loss_d == pfgp_pkg::PFGP_RUN);
    assign boot_target =
        (loss_q == pfgp_pkg::PFGP_PG_LOW) ? pfgp_pkg::PFGP_S0 :
        !policy_q ? pfgp_pkg::PFGP_S0 :
        was_s4_q ? pfgp_pkg::PFGP_S4 : pfgp_pkg::PFGP_S5;

    // state register and S4 memory
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            loss_q <= pfgp_pkg::PFGP_RUN;
            was_s4_q <= 1'b0;
        end else begin
            loss_q <= loss_d;
            if (loss_q == pfgp_pkg::PFGP_RUN) begin
                was_s4_q <= (sleep_state == pfgp_pkg::PFGP_S4);
            end
        end
    end

    // boot request pulse, target and internal resume reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_req_q <= 1'b0;
            boot_state_q <= pfgp_pkg::PFGP_S0;
            int_resume_reset_q <= 1'b1;
        end else begin
            boot_req_q <= boot_go;
            if (boot_go) begin
                boot_state_q <= boot_target;
            end
            int_resume_reset_q <= ~rsm_n_s | ~pg_s;
        end
    end

    // ------------------------------------------------------------------
    // status flags and policy bit
    // ------------------------------------------------------------------
    logic pg_fail_q; // power_good_failure_flag
    logic rtc_batt_q; // rtc_battery_failure_flag
    logic trickle_q; // trickle_power_failure_flag
    logic pg_fail_set; // power-good drop in S0 or S1 with resume power up

    assign pg_fail_set = pg_fall & in_s0_s1 & rsm_n_s;

    // power-good failure: set wins over clear, G3 clears
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pg_fail_q <= 1'b0;
        end else if (pg_fail_set) begin
            pg_fail_q <= 1'b1;
        end else if (pg_fail_clr || g3_enter) begin
            pg_fail_q <= 1'b0;
        end
    end

    // RTC-well flags: the RTC reset or software touches them; the resume reset also sets trickle
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rtc_batt_q <= 1'b1;
            trickle_q <= 1'b0;
            policy_q <= 1'b0;
        end else begin
            if (!rtc_n_s) begin
                rtc_batt_q <= 1'b1;
            end else if (rtc_batt_clr) begin
                rtc_batt_q <= 1'b0;
            end
            if (!rtc_n_s) begin
                trickle_q <= 1'b0;
            end else if (rsm_fall) begin
                trickle_q <= 1'b1;
            end else if (trickle_clr) begin
                trickle_q <= 1'b0;
            end
            if (!rtc_n_s || rst_ctl_wr) begin
                policy_q <= 1'b0;
            end else if (wr_three) begin
                policy_q <= cfg_wdata[pfgp_pkg::PFGP_BIT_POLICY];
            end
        end
    end

    // ------------------------------------------------------------------
    // wake filtering after a power-loss S5
    // ------------------------------------------------------------------
    logic held_off_q; // parked in S5 by the policy
    logic wake_ok; // an allowed wake source fired

    assign wake_ok = power_button | (|(wake_event & wake_kept_en));

    // park on policy S5, leave on the first allowed wake
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            held_off_q <= 1'b0;
            wake_accept_q <= 1'b0;
        end else begin
            wake_accept_q <= held_off_q & wake_ok;
            if (boot_go) begin
                held_off_q <= (boot_target == pfgp_pkg::PFGP_S5);
            end else if (wake_ok) begin
                held_off_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration read path
    // ------------------------------------------------------------------
    logic [15:0] rd_two; // power_config_two image
    logic [15:0] rd_three; // power_config_three image
    logic [15:0] rd_mux; // selected read data

    assign rd_two = {15'h0000, pg_fail_q};
    assign rd_three = {13'h0000, rtc_batt_q, trickle_q, policy_q};
    assign rd_mux = (cfg_addr == pfgp_pkg::PFGP_OFS_CFG_TWO) ? rd_two :
                    (cfg_addr == pfgp_pkg::PFGP_OFS_CFG_THREE) ? rd_three :
                    16'h0000;

    // read data register, updated on each read strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata_q <= pfgp_pkg::PFGP_RST_CFG_TWO;
        end else if (cfg_rd) begin
            cfg_rdata_q <= rd_mux;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    a_pg_fail_set: assert property (pg_fail_set |=> pg_fail_q)
        else $error("power-good failure flag not set");
    a_pg_fail_hold: assert property (
        $fell(pg_fail_q) |-> $past(pg_fail_clr) || $past(g3_enter))
        else $error("power-good failure flag cleared without cause");
    a_pg_pulse_reboot: assert property (
        (loss_q == pfgp_pkg::PFGP_PG_LOW && rsm_n_s && pg_s)
        |=> boot_req_q && boot_state_q == pfgp_pkg::PFGP_S0)
        else $error("power-good pulse did not reboot to S0");
    a_int_reset: assert property (
        (!pg_s && rsm_n_s) |=> int_resume_reset_q)
        else $error("power-good drop not seen as resume reset");
    a_batt_set: assert property (
        !rtc_n_s |=> rtc_batt_q && !trickle_q && !policy_q)
        else $error("RTC reset did not set battery flag");
    a_batt_clear: assert property (
        (rtc_n_s && wr_three && cfg_wdata[pfgp_pkg::PFGP_BIT_RTC_BATT])
        |=> $stable(rtc_batt_q))
        else $error("battery flag changed by write of one");
    a_trickle_set: assert property (
        (rsm_fall && rtc_n_s) |=> trickle_q)
        else $error("trickle flag not set on resume reset");
    a_trickle_keep: assert property (
        $fell(trickle_q) |-> $past(trickle_clr) || !$past(rtc_n_s))
        else $error("trickle flag lost without clear");
    a_policy_target: assert property (
        (boot_go && loss_q == pfgp_pkg::PFGP_G3 && policy_q && !was_s4_q)
        |=> boot_state_q == pfgp_pkg::PFGP_S5)
        else $error("policy one did not select S5");
    a_policy_clear: assert property (rst_ctl_wr |=> !policy_q)
        else $error("reset-control write left policy set");
    a_wake_gate: assert property (
        wake_accept_q |-> $past(held_off_q) && $past(wake_ok))
        else $error("wake accepted from disallowed source");
    a_reserved_zero: assert property (
        $past(cfg_rd) |-> cfg_rdata_q[15:3] == 13'h0000)
        else $error("reserved read bits not zero");

endmodule : pfgp_top

// >>> bench/pfgp_supply.sv
// Purpose: model of the supply side: power-good and the two well resets
// Assumes: the bench calls the tasks just after a falling clock edge
// Notes:   all three lines are driven levels, never released

`timescale 1ns/10ps

// ----------------------------------------------------------------------
// supply model
// ----------------------------------------------------------------------
module pfgp_supply (
    output logic power_good_input,
    output logic resume_well_reset_n,
    output logic rtc_well_reset_n
);
    // power is present and stable when the run starts
    initial begin
        power_good_input = 1'b1;
        resume_well_reset_n = 1'b1;
        rtc_well_reset_n = 1'b1;
    end

    // drop or restore the power-good line
    task automatic set_pg(input logic v);
        power_good_input = v;
    endtask : set_pg

    // remove or restore trickle power, seen as the resume reset
    task automatic set_rsm(input logic v);
        resume_well_reset_n = v;
    endtask : set_rsm

    // pull or release the rtc-well reset jumper
    task automatic set_rtc(input logic v);
        rtc_well_reset_n = v;
    endtask : set_rtc
endmodule : pfgp_supply

// >>> bench/tb.sv
// Purpose: self-checking bench for the power-failure status block
// Assumes: inputs change on the falling edge; pins settle in 8 cycles
// Notes:   each scenario is one task that judges its own results

`timescale 1ns/10ps

module tb;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst_b;
    logic [2:0] sleep_state;
    logic cfg_wr;
    logic cfg_rd;
    logic [7:0] cfg_addr;
    logic [1:0] cfg_be; // all fields live in the low byte
    logic [15:0] cfg_wdata;
    logic rst_ctl_wr;
    logic power_button;
    logic [7:0] wake_event;
    logic [7:0] wake_kept_en;
    logic pg, rsm_n, rtc_n;
    logic [15:0] cfg_rdata_q;
    logic boot_req_q, int_resume_reset_q, wake_accept_q;
    logic [2:0] boot_state_q;
    logic [15:0] v;
    logic [2:0] st;
    int err_count = 0;
    int checks = 0;
    int n;
    bit timed_out = 1'b0; // a bounded wait ran out

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    pfgp_supply sup (
        .power_good_input(pg),
        .resume_well_reset_n(rsm_n),
        .rtc_well_reset_n(rtc_n)
    );

    pfgp_top #(.WAKE_W(8)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .power_good_input(pg),
        .resume_well_reset_n(rsm_n), .rtc_well_reset_n(rtc_n),
        .sleep_state(sleep_state), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .rst_ctl_wr(rst_ctl_wr), .power_button(power_button),
        .wake_event(wake_event), .wake_kept_en(wake_kept_en),
        .cfg_rdata_q(cfg_rdata_q), .boot_req_q(boot_req_q),
        .boot_state_q(boot_state_q),
        .int_resume_reset_q(int_resume_reset_q),
        .wake_accept_q(wake_accept_q)
    );

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    // compare one value, report and count a mismatch
    task automatic chk(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask : cyc

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge ref_clk);
        cfg_wr = 1'b0;
    endtask : wr

    // one-cycle read strobe, data taken a cycle later
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge ref_clk);
        cfg_rd = 1'b0;
        @(negedge ref_clk);
        d = cfg_rdata_q;
    endtask : rd

    // bounded wait for the boot pulse, then check it lasts one cycle
    task automatic wait_boot(output logic [2:0] s);
        int i = 0;
        while (boot_req_q !== 1'b1 && i < 60) begin
            @(negedge ref_clk);
            i++;
        end
        s = boot_state_q;
        if (i == 60) begin
            err_count++;
            timed_out = 1'b1;
        end else begin
            @(negedge ref_clk);
            chk("boot pulse width", {15'h0, boot_req_q}, 16'h0000);
        end
    endtask : wait_boot

    // count accepted wakes; the button is a one-cycle pulse
    task automatic count_wake(output int c);
        c = 0;
        repeat (6) begin
            @(negedge ref_clk);
            power_button = 1'b0;
            if (wake_accept_q === 1'b1)
                c++;
        end
    endtask : count_wake

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic sc_regs();
        rd(8'ha4, v); chk("battery after reset", v, 16'h0004);
        wr(8'ha4, 16'h0004);
        rd(8'ha4, v); chk("battery kept on one", v, 16'h0004);
        cfg_be = 2'h2; // low lane off: the write must not land
        wr(8'ha4, 16'h0000);
        cfg_be = 2'h1;
        rd(8'ha4, v); chk("battery kept, lane off", v, 16'h0004);
        wr(8'ha4, 16'hfff8);
        rd(8'ha4, v); chk("battery clear", v, 16'h0000);
        wr(8'ha2, 16'hfffe);
        rd(8'ha2, v); chk("reserved two", v, 16'h0000);
        rd(8'ha0, v); chk("unmapped read", v, 16'h0000);
    endtask : sc_regs

    // power-good pulse with resume power kept: internal reset, reboot
    task automatic sc_pg_pulse();
        wr(8'ha4, 16'h0005); // policy 1, battery untouched
        sup.set_pg(1'b0);
        cyc(8);
        chk("internal reset", {15'h0, int_resume_reset_q}, 16'h1);
        rd(8'ha2, v); chk("pg flag set", v, 16'h0001);
        rd(8'ha4, v); chk("no trickle flag", v, 16'h0001);
        sup.set_pg(1'b1);
        wait_boot(st);
        chk("reboot ignores policy", {13'h0, st}, 16'h0000);
        wr(8'ha2, 16'h0000);
        rd(8'ha2, v); chk("pg flag kept", v, 16'h0001);
        wr(8'ha2, 16'h0001);
        rd(8'ha2, v); chk("pg flag cleared", v, 16'h0000);
        sleep_state = pfgp_pkg::PFGP_S3; // drop outside S0/S1
        sup.set_pg(1'b0);
        cyc(8);
        rd(8'ha2, v); chk("pg flag in s3", v, 16'h0000);
        sup.set_pg(1'b1);
        wait_boot(st);
        sleep_state = pfgp_pkg::PFGP_S0;
    endtask : sc_pg_pulse

    // full failure: resume reset falls before power good returns
    task automatic sc_loss(input logic pol, input logic [2:0] s,
                           input logic [2:0] exp);
        wr(8'ha4, {15'h0, pol});
        sleep_state = s;
        sup.set_pg(1'b0);
        cyc(8);
        sup.set_rsm(1'b0);
        cyc(8);
        rd(8'ha2, v); chk("g3 clears pg flag", v, 16'h0000);
        rd(8'ha4, v);
        chk("trickle set", v, {14'h0, 1'b1, pol});
        sup.set_rsm(1'b1);
        cyc(8);
        rd(8'ha4, v);
        chk("trickle survives", v, {14'h0, 1'b1, pol});
        sup.set_pg(1'b1);
        wait_boot(st);
        chk("boot target", {13'h0, st}, {13'h0, exp});
        sleep_state = exp;
        wr(8'ha4, {13'h0, 2'h3, pol});
        rd(8'ha4, v); chk("trickle clear", v, {15'h0, pol});
    endtask : sc_loss

    // parked in policy S5: only the button or kept enables wake
    task automatic sc_wake(input logic btn);
        wake_kept_en = 8'h02;
        wake_event = 8'h01;
        count_wake(n);
        chk("unkept wake", n[15:0], 16'h0000);
        if (btn) begin
            wake_event = 8'h00;
            power_button = 1'b1;
        end else begin
            wake_event = 8'h02;
        end
        count_wake(n);
        chk("allowed wake", n[15:0], 16'h0001);
        wake_event = 8'h00;
        wake_kept_en = 8'h00;
    endtask : sc_wake

    // rtc reset and reset-control write both clear the policy bit
    task automatic sc_policy_clear();
        wr(8'ha4, 16'h0001);
        sup.set_rtc(1'b0);
        cyc(8);
        sup.set_rtc(1'b1);
        cyc(8);
        rd(8'ha4, v); chk("rtc reset", v, 16'h0004);
        wr(8'ha4, 16'h0001);
        rst_ctl_wr = 1'b1;
        cyc(1);
        rst_ctl_wr = 1'b0;
        rd(8'ha4, v); chk("reset-control write", v, 16'h0000);
    endtask : sc_policy_clear

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        sleep_state = pfgp_pkg::PFGP_S0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 2'h1;
        cfg_wdata = 16'h0000;
        rst_ctl_wr = 1'b0;
        power_button = 1'b0;
        wake_event = 8'h00;
        wake_kept_en = 8'h00;
        cyc(3);
        rst_b = 1'b1;
        cyc(12);
        sc_regs();
        if (!timed_out) sc_pg_pulse();
        if (!timed_out) sc_loss(1'b0, pfgp_pkg::PFGP_S0, pfgp_pkg::PFGP_S0);
        if (!timed_out) sc_loss(1'b1, pfgp_pkg::PFGP_S4, pfgp_pkg::PFGP_S4);
        if (!timed_out) sc_loss(1'b1, pfgp_pkg::PFGP_S0, pfgp_pkg::PFGP_S5);
        if (!timed_out) sc_wake(1'b0);
        if (!timed_out) sc_loss(1'b1, pfgp_pkg::PFGP_S0, pfgp_pkg::PFGP_S5);
        if (!timed_out) sc_wake(1'b1);
        if (!timed_out) sc_policy_clear();
        print_verdict();
    end
endmodule : tb
